// ==== core/flash_regs.svh ====
// opcodes, address masks and timing constants of the program/erase sequencer
`ifndef FLASH_REGS_SVH
`define FLASH_REGS_SVH
`define OP_WREN        8'h06
`define OP_WRDI        8'h04
`define OP_PROG        8'h02
`define OP_QPROG       8'h32
`define OP_SE          8'h20
`define OP_BE32        8'h52
`define OP_BE64        8'hd8
`define OP_CE1         8'hc7
`define OP_CE2         8'h60
`define OP_SUSP        8'h75
`define OP_RESUME      8'h7a
`define ERASED_BYTE    8'hff
`define LAST_COL       8'hff
`define NB_ONE         3'd1
`define NB_LAST_ADDR   3'd3
`define HDR_BYTES      3'd4
`define NB_SAT         3'd5
`define PAGE_BYTES     256
`define PAGE_MASK      24'hffff00
`define SECTOR_MASK    24'hfff000
`define BLK32_MASK     24'hff8000
`define BLK64_MASK     24'hff0000
`define CHIP_MASK      24'h000000
`define CLK_MHZ        10
`define CLK_PERIOD_NS  100
`define RESUME_BUSY_NS 200
`define SUSP_LAT_US    20
`define PROG_TIME_US   700
`define SE_TIME_US     45000
`define BE32_TIME_US   120000
`define BE64_TIME_US   150000
`define CE_TIME_US     40000000
`endif

// ==== core/flash_pkg.sv ====
// types shared by the program/erase sequencer
package flash_pkg;
  typedef enum logic [2:0] {
    OPK_NONE = 3'b000,
    OPK_PROG = 3'b001,
    OPK_SE   = 3'b010,
    OPK_BE32 = 3'b011,
    OPK_BE64 = 3'b100,
    OPK_CE   = 3'b101
  } op_kind_t;
  typedef enum logic [2:0] {
    R_IDLE      = 3'b000,
    R_RUN       = 3'b001,
    R_WRITE     = 3'b010,
    R_SUSP_WAIT = 3'b011,
    R_SUSP      = 3'b100,
    R_RESUME    = 3'b101
  } run_state_t;
endpackage

// ==== core/serial_rx.sv ====
// serial pin synchroniser and byte assembler, one or four bits per serial clock
`timescale 1ns/10ps
module serial_rx (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       cs_n_pin,
  input  wire logic       sclk_pin,
  input  wire logic [3:0] io_pin,
  input  wire logic       wide,
  output logic            byte_valid,
  output logic [7:0]      byte_data,
  output logic            cs_fall,
  output logic            cs_rise,
  output logic            aligned
);
  logic [1:0] cs_s;
  logic [1:0] ck_s;
  logic [3:0] io_m;
  logic [3:0] io_s;
  logic       cs_d;
  logic       ck_d;
  logic [2:0] bcnt_q;
  logic [7:0] sh_q;
  logic [2:0] bcnt_d;
  logic [7:0] sh_d;
  logic       sck_rise;

  always_ff @(posedge clk) begin
    if (srst) begin
      cs_s <= 2'h3;
      ck_s <= 2'h0;
      io_m <= 4'h0;
      io_s <= 4'h0;
      cs_d <= 1'b1;
      ck_d <= 1'b0;
    end else begin
      cs_s <= {cs_s[0], cs_n_pin};
      ck_s <= {ck_s[0], sclk_pin};
      io_m <= io_pin;
      io_s <= io_m;
      cs_d <= cs_s[1];
      ck_d <= ck_s[1];
    end
  end

  assign sck_rise = ck_s[1] & ~ck_d & ~cs_s[1];
  assign cs_fall  = cs_d & ~cs_s[1];
  assign cs_rise  = ~cs_d & cs_s[1];
  assign aligned  = (bcnt_q == 3'h0);
  assign bcnt_d   = wide ? bcnt_q + 3'h4 : bcnt_q + 3'h1;
  assign sh_d     = wide ? {sh_q[3:0], io_s} : {sh_q[6:0], io_s[0]};

  always_ff @(posedge clk) begin
    if (srst || cs_fall) begin
      bcnt_q     <= 3'h0;
      sh_q       <= 8'h0;
      byte_valid <= 1'b0;
      byte_data  <= 8'h0;
    end else begin
      byte_valid <= sck_rise && (bcnt_d == 3'h0);
      if (sck_rise) begin
        bcnt_q <= bcnt_d;
        sh_q   <= sh_d;
        if (bcnt_d == 3'h0) begin
          byte_data <= sh_d;
        end
      end
    end
  end
endmodule

// ==== core/flash_program_erase_suspend.sv ====
// program, erase, suspend and resume sequencer of the serial flash device
`timescale 1ns/10ps
`include "flash_regs.svh"
// Overview of operation
// - quad page program 32h taken only with quad enable set; data on four lines
// - page program loads up to 256 bytes, four bits per clock in quad form
// - program and erase refused unless the write enable latch is set
// - opcode 20h with address erases the 4K sector to all ones
// - opcode 52h with address erases the 32K block to all ones
// - opcode D8h with address erases the 64K block to all ones
// - opcode C7h or 60h erases the whole array to all ones
// - chip select must rise on a byte boundary, else the command is dropped
// - chip select rise starts the timed cycle; busy stays high until done
// - status polling stays possible while a cycle runs
// - finishing a program or erase clears the write enable latch
// - program or unit erase into a protected region is skipped
// - chip erase skipped while any region is protected
// - suspend 75h taken only when not suspended and busy with program or unit erase
// - suspend during chip erase is ignored
// - during erase suspend, status writes and all erases are not executed
// - during program suspend, status writes and programs are not executed
// - accepted suspend sets suspended flag at once, busy falls within suspend latency
// - while suspended, other sectors or blocks may be programmed or erased
// - reset clears the suspended flag
// - program data past the page end wraps to the page start
// - resume 7Ah taken only when suspended and idle; busy returns within 200ns
module flash_program_erase_suspend #(
  parameter logic [31:0] PROG_CYCLES = 32'(`PROG_TIME_US * `CLK_MHZ),
  parameter logic [31:0] SE_CYCLES   = 32'(`SE_TIME_US * `CLK_MHZ),
  parameter logic [31:0] BE32_CYCLES = 32'(`BE32_TIME_US * `CLK_MHZ),
  parameter logic [31:0] BE64_CYCLES = 32'(`BE64_TIME_US * `CLK_MHZ),
  parameter logic [31:0] CE_CYCLES   = 32'(`CE_TIME_US * `CLK_MHZ)
) (
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          cs_n_pin,
  input  wire logic          sclk_pin,
  input  wire logic [3:0]    io_pin,
  input  wire logic          quad_io_enable_bit,
  input  wire logic          four_wire_command_framing,
  input  wire logic          target_protected,
  input  wire logic          any_region_protected,
  output logic [23:0]        protect_query_addr,
  output logic               write_enable_latch,
  output logic               busy_flag,
  output logic               suspended_flag,
  output logic               prog_we,
  output logic [23:0]        prog_addr,
  output logic [7:0]         prog_data,
  output logic               erase_go,
  output flash_pkg::op_kind_t erase_kind,
  output logic [23:0]        erase_base,
  output logic [7:0]         erase_fill
);
  import flash_pkg::*;

  localparam logic [15:0] SUSP_CYC   = 16'(`SUSP_LAT_US * `CLK_MHZ);
  localparam logic [15:0] RESUME_CYC = 16'(`RESUME_BUSY_NS / `CLK_PERIOD_NS);
  localparam int          SUSP_I     = `SUSP_LAT_US * `CLK_MHZ;

  logic        byte_valid;
  logic        cs_fall;
  logic        cs_rise;
  logic        aligned;
  logic        wide;
  logic [7:0]  byte_data;
  logic [7:0]  cmd_q;
  logic [23:0] arx_q;
  logic [2:0]  nb_q;
  logic [7:0]  col_q;
  logic [7:0]  pbuf [`PAGE_BYTES];
  logic [`PAGE_BYTES-1:0] pmask_q;
  run_state_t  st_q;
  op_kind_t    op_q;
  op_kind_t    sv_op_q;
  op_kind_t    kind;
  logic [23:0] addr_q;
  logic [23:0] sv_addr_q;
  logic [31:0] cnt_q;
  logic [31:0] sv_cnt_q;
  logic [31:0] cyc_new;
  logic [15:0] lat_q;
  logic        sus_q;
  logic        nest_q;
  logic        wel_q;
  logic [7:0]  wcol_q;
  logic        len_ok;
  logic        clash;
  logic        susp_ok;
  logic        protd;
  logic        frame_ok;
  logic        single;
  logic        mode_ok;
  logic        go;
  logic        susp_go;
  logic        res_go;
  logic        buf_free;
  logic        load;
  logic        finish;

  function automatic logic [23:0] unit_mask(input op_kind_t k);
    case (k)
      OPK_PROG: unit_mask = `SECTOR_MASK;
      OPK_SE:   unit_mask = `SECTOR_MASK;
      OPK_BE32: unit_mask = `BLK32_MASK;
      OPK_BE64: unit_mask = `BLK64_MASK;
      default:  unit_mask = `CHIP_MASK;
    endcase
  endfunction

  serial_rx u_rx (
    .clk        (clk),
    .srst       (srst),
    .cs_n_pin   (cs_n_pin),
    .sclk_pin   (sclk_pin),
    .io_pin     (io_pin),
    .wide       (wide),
    .byte_valid (byte_valid),
    .byte_data  (byte_data),
    .cs_fall    (cs_fall),
    .cs_rise    (cs_rise),
    .aligned    (aligned)
  );

  // quad data phase of 32h only with quad enable; four-wire framing widens every byte
  assign wide = four_wire_command_framing ||
                (cmd_q == `OP_QPROG && quad_io_enable_bit && nb_q >= `HDR_BYTES);

  assign kind = (cmd_q == `OP_PROG || (cmd_q == `OP_QPROG && quad_io_enable_bit)) ? OPK_PROG :
                (cmd_q == `OP_SE)   ? OPK_SE   :
                (cmd_q == `OP_BE32) ? OPK_BE32 :
                (cmd_q == `OP_BE64) ? OPK_BE64 :
                (cmd_q == `OP_CE1 || cmd_q == `OP_CE2) ? OPK_CE : OPK_NONE;

  assign cyc_new = (kind == OPK_PROG) ? PROG_CYCLES - 32'h1 :
                   (kind == OPK_SE)   ? SE_CYCLES - 32'h1   :
                   (kind == OPK_BE32) ? BE32_CYCLES - 32'h1 :
                   (kind == OPK_BE64) ? BE64_CYCLES - 32'h1 : CE_CYCLES - 32'h1;

  // exact byte count for erases, at least one data byte for program, and boundary at chip select rise
  assign frame_ok = cs_rise && aligned;
  assign single   = frame_ok && nb_q == `NB_ONE;
  assign len_ok   = (kind == OPK_PROG) ? nb_q == `NB_SAT :
                    (kind == OPK_CE)   ? nb_q == `NB_ONE : nb_q == `HDR_BYTES;

  // target must lie outside the interrupted unit
  assign clash = ((arx_q ^ sv_addr_q) & unit_mask(kind) & unit_mask(sv_op_q)) == 24'h0;
  // program suspend admits unit erases only
  assign susp_ok = (sv_op_q == OPK_PROG) ? (kind != OPK_PROG && kind != OPK_CE) : (kind == OPK_PROG);
  // region check for program and unit erase
  // chip erase needs no protected region
  assign protd   = (kind == OPK_CE) ? any_region_protected : target_protected;
  assign mode_ok = (st_q == R_IDLE && !sus_q) || (st_q == R_SUSP && susp_ok && !clash);
  // write enable latch gates every start
  assign go      = frame_ok && len_ok && kind != OPK_NONE && wel_q && !protd && mode_ok;
  // suspend only from a running cycle
  assign susp_go = single && cmd_q == `OP_SUSP && st_q == R_RUN && !sus_q && op_q != OPK_CE;
  // resume only when suspended and idle
  assign res_go  = single && cmd_q == `OP_RESUME && st_q == R_SUSP;

  assign buf_free = !((st_q != R_IDLE && op_q == OPK_PROG) || (sus_q && sv_op_q == OPK_PROG));
  // bytes count only within one low chip select
  assign load     = byte_valid && nb_q >= `HDR_BYTES && kind == OPK_PROG && buf_free;
  // an accepted suspend outranks the end of the count, so no erase fires before it
  assign finish   = (st_q == R_RUN && cnt_q == 32'h0 && op_q != OPK_PROG && !susp_go) ||
                    (st_q == R_WRITE && wcol_q == `LAST_COL);

  assign protect_query_addr = arx_q;
  assign write_enable_latch = wel_q;
  assign suspended_flag     = sus_q;
  // busy through the whole cycle and suspend latency
  assign busy_flag = st_q == R_RUN || st_q == R_WRITE || st_q == R_SUSP_WAIT;
  assign erase_fill = `ERASED_BYTE;

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_q <= 8'h0;
      arx_q <= 24'h0;
      nb_q  <= 3'h0;
      col_q <= 8'h0;
    end else if (cs_fall) begin
      nb_q <= 3'h0;
    end else if (byte_valid) begin
      if (nb_q != `NB_SAT) begin
        nb_q <= nb_q + 3'h1;
      end
      if (nb_q == 3'h0) begin
        cmd_q <= byte_data;
      end else if (nb_q < `HDR_BYTES) begin
        arx_q <= {arx_q[15:0], byte_data};
      end
      if (nb_q == `NB_LAST_ADDR) begin
        col_q <= byte_data;
      end else if (load) begin
        col_q <= col_q + 8'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (load) begin
      pbuf[col_q] <= byte_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || (cs_fall && buf_free)) begin
      pmask_q <= '0;
    end else if (load) begin
      pmask_q[col_q] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wel_q <= 1'b0;
    end else begin
      // latch cleared at the end of a cycle
      if (finish || (single && !busy_flag && cmd_q == `OP_WRDI)) begin
        wel_q <= 1'b0;
      end
      if (single && !busy_flag && cmd_q == `OP_WREN) begin
        wel_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q      <= R_IDLE;
      op_q      <= OPK_NONE;
      sv_op_q   <= OPK_NONE;
      addr_q    <= 24'h0;
      sv_addr_q <= 24'h0;
      cnt_q     <= 32'h0;
      sv_cnt_q  <= 32'h0;
      lat_q     <= 16'h0;
      sus_q     <= 1'b0;
      nest_q    <= 1'b0;
      wcol_q    <= 8'h0;
    end else begin
      case (st_q)
        R_IDLE, R_SUSP: begin
          if (go) begin
            // erase base aligned to the unit
            op_q   <= kind;
            addr_q <= arx_q & ((kind == OPK_PROG) ? `PAGE_MASK : unit_mask(kind));
            cnt_q  <= cyc_new;
            nest_q <= (st_q == R_SUSP);
            st_q   <= R_RUN;
          end else if (res_go) begin
            sus_q  <= 1'b0;
            op_q   <= sv_op_q;
            addr_q <= sv_addr_q;
            cnt_q  <= sv_cnt_q;
            lat_q  <= RESUME_CYC;
            st_q   <= R_RESUME;
          end
        end
        R_RUN: begin
          if (susp_go) begin
            // flag at once, busy after latency
            sus_q <= 1'b1;
            lat_q <= SUSP_CYC;
            st_q  <= R_SUSP_WAIT;
          end else if (cnt_q != 32'h0) begin
            cnt_q <= cnt_q - 32'h1;
          end else if (op_q == OPK_PROG) begin
            wcol_q <= 8'h0;
            st_q   <= R_WRITE;
          end else begin
            nest_q <= 1'b0;
            st_q   <= nest_q ? R_SUSP : R_IDLE;
          end
        end
        R_WRITE: begin
          if (wcol_q == `LAST_COL) begin
            nest_q <= 1'b0;
            st_q   <= nest_q ? R_SUSP : R_IDLE;
          end else begin
            wcol_q <= wcol_q + 8'h1;
          end
        end
        R_SUSP_WAIT: begin
          if (lat_q <= 16'h1) begin
            sv_op_q   <= op_q;
            sv_addr_q <= addr_q;
            sv_cnt_q  <= cnt_q;
            st_q      <= R_SUSP;
          end else begin
            lat_q <= lat_q - 16'h1;
          end
        end
        R_RESUME: begin
          if (lat_q <= 16'h1) begin
            st_q <= R_RUN;
          end else begin
            lat_q <= lat_q - 16'h1;
          end
        end
        default: st_q <= R_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prog_we    <= 1'b0;
      prog_addr  <= 24'h0;
      prog_data  <= 8'h0;
      erase_go   <= 1'b0;
      erase_kind <= OPK_NONE;
      erase_base <= 24'h0;
    end else begin
      prog_we    <= st_q == R_WRITE && pmask_q[wcol_q];
      prog_addr  <= addr_q | 24'(wcol_q);
      prog_data  <= pbuf[wcol_q];
      // unit or chip erase issued at the end
      erase_go   <= finish && op_q != OPK_PROG;
      erase_kind <= op_q;
      erase_base <= addr_q;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence susp_start_s;
    suspended_flag && busy_flag;
  endsequence
  sequence busy_fall_s;
    ##[0:SUSP_I] !busy_flag;
  endsequence

  start_busy_a: assert property (go && st_q == R_IDLE |=> busy_flag && st_q == R_RUN)
    else $error("busy not raised at start");
  wel_clear_a: assert property (finish |=> !write_enable_latch)
    else $error("write enable latch kept after cycle");
  no_wel_a: assert property (cs_rise && !write_enable_latch && st_q == R_IDLE |=> !busy_flag)
    else $error("start without write enable");
  protect_a: assert property (cs_rise && target_protected && kind != OPK_CE && st_q == R_IDLE
                               |=> st_q == R_IDLE)
    else $error("protected target started");
  ce_protect_a: assert property (cs_rise && any_region_protected && kind == OPK_CE && st_q == R_IDLE
                                  |=> st_q == R_IDLE)
    else $error("chip erase under protection");
  suspend_seq_a: assert property (susp_go |=> susp_start_s ##0 busy_fall_s)
    else $error("suspend flag or busy wrong");
  ce_nosusp_a: assert property (single && cmd_q == `OP_SUSP && op_q == OPK_CE && st_q == R_RUN
                                 |=> !suspended_flag && busy_flag)
    else $error("chip erase was suspended");
  resume_busy_a: assert property (res_go |=> (!suspended_flag && !busy_flag) [*2] ##1 busy_flag)
    else $error("resume timing wrong");
  misalign_a: assert property (cs_rise && !aligned && st_q == R_IDLE |=> st_q == R_IDLE)
    else $error("misaligned command executed");
  page_wrap_a: assert property (load && col_q == `LAST_COL |=> col_q == 8'h0)
    else $error("page column did not wrap");
endmodule

// ==== testbench/flash_host_model.sv ====
// host controller model driving the serial link of the flash device
`timescale 1ns/10ps
module flash_host_model (
  input  wire logic       clk,
  output logic            cs_n_pin,
  output logic            sclk_pin,
  output logic [3:0]      io_pin
);
  int since_resume = 1000;

  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    io_pin   = 4'h5;
  end

  always @(posedge clk) begin
    since_resume <= since_resume + 1;
  end

  // n bits msb first, the last nq of them four per serial clock
  task automatic frame(input int n, input logic [63:0] v, input int nq);
    int i;
    i = n;
    // no suspend soon after a resume
    while (n == 8 && v[7:0] == 8'h75 && since_resume < 220) @(negedge clk);
    @(negedge clk);
    // select held low for the whole command
    cs_n_pin = 1'b0;
    while (i > 0) begin
      if (i > nq) begin
        io_pin = {~io_pin[3:1], v[i-1]};
        i = i - 1;
      end else begin
        io_pin = v[i-1 -: 4];
        i = i - 4;
      end
      repeat (4) @(negedge clk);
      sclk_pin = 1'b1;
      repeat (4) @(negedge clk);
      sclk_pin = 1'b0;
    end
    repeat (2) @(negedge clk);
    // select rises after the last bit
    cs_n_pin = 1'b1;
    io_pin   = ~io_pin;
    if (n == 8 && v[7:0] == 8'h7a) since_resume = 0;
    repeat (8) @(negedge clk);
  endtask
endmodule

// ==== testbench/test_flash_program_erase_suspend.sv ====
// self-checking bench of the program/erase/suspend sequencer
`timescale 1ns/10ps
`include "flash_regs.svh"
module test_flash_program_erase_suspend;
  import flash_pkg::*;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        quad_io_enable_bit = 1'b0;
  logic        four_wire_command_framing = 1'b0;
  logic        target_protected = 1'b0;
  logic        any_region_protected = 1'b0;
  logic        cs_n_pin, sclk_pin, write_enable_latch, busy_flag, suspended_flag, prog_we, erase_go;
  logic [3:0]  io_pin;
  logic [23:0] protect_query_addr, prog_addr, erase_base, go_base, a, we_addr;
  logic [7:0]  prog_data, erase_fill;
  logic [7:0]  col_data [256];
  op_kind_t    erase_kind, go_kind;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          n_we = 0;
  int          n_go = 0;
  logic [7:0]  ops [5] = '{`OP_SE, `OP_BE32, `OP_BE64, `OP_CE1, `OP_CE2};
  op_kind_t    kinds [5] = '{OPK_SE, OPK_BE32, OPK_BE64, OPK_CE, OPK_CE};

  flash_program_erase_suspend #(
    .PROG_CYCLES(32'd400), .SE_CYCLES(32'd1500), .BE32_CYCLES(32'd30),
    .BE64_CYCLES(32'd40), .CE_CYCLES(32'd600)
  ) flash_program_erase_suspend_inst (
    .clk, .srst, .cs_n_pin, .sclk_pin, .io_pin, .quad_io_enable_bit, .four_wire_command_framing,
    .target_protected, .any_region_protected, .protect_query_addr, .write_enable_latch,
    .busy_flag, .suspended_flag, .prog_we, .prog_addr, .prog_data, .erase_go, .erase_kind,
    .erase_base, .erase_fill
  );
  flash_host_model flash_host_model_inst (.clk, .cs_n_pin, .sclk_pin, .io_pin);

  always #50 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (prog_we) begin
      n_we <= n_we + 1;
      col_data[prog_addr[7:0]] <= prog_data;
      we_addr <= prog_addr;
    end
    if (erase_go) begin
      n_go <= n_go + 1;
      go_kind <= erase_kind;
      go_base <= erase_base;
    end
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [23:0] exp_base(input op_kind_t k, input logic [23:0] adr);
    case (k)
      OPK_SE:   return adr & `SECTOR_MASK;
      OPK_BE32: return adr & `BLK32_MASK;
      OPK_BE64: return adr & `BLK64_MASK;
      default:  return 24'h000000;
    endcase
  endfunction

  task automatic cmd(input logic [7:0] op, input logic [23:0] adr, input bit with_adr);
    int w;
    w = four_wire_command_framing ? 64 : 0;
    if (with_adr)
      flash_host_model_inst.frame(32, {32'h0, op, adr}, w);
    else
      flash_host_model_inst.frame(8, {56'h0, op}, w);
  endtask

  task automatic wren();
    cmd(`OP_WREN, 24'h0, 1'b0);
  endtask

  task automatic prog(input logic [7:0] op, input logic [23:0] adr, input logic [23:0] d, input int nb);
    flash_host_model_inst.frame(32 + 8 * nb, ({32'h0, op, adr} << (8 * nb)) | 64'(d),
                                op == `OP_QPROG ? 8 * nb : 0);
  endtask

  task automatic wait_busy(input logic lvl, input int lim);
    int k;
    k = 0;
    while (busy_flag !== lvl && k < lim) begin
      @(negedge clk);
      k++;
    end
    // registered strobes rise on the edge where busy falls, the bench captures them one edge later
    repeat (2) @(negedge clk);
  endtask

  task automatic do_reset();
    srst = 1'b1;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  initial begin
    void'($urandom(15));
    do_reset();
    wren();
    cmd(`OP_WRDI, 24'h0, 1'b0);
    check("latch dropped", 0, write_enable_latch);
    cmd(`OP_SE, 24'h001000, 1'b1);
    check("busy without latch", 0, busy_flag);
    $display("test no_latch done");
    for (int i = 0; i < 5; i++) begin
      four_wire_command_framing = i[0];
      a = 24'($urandom);
      wren();
      check("latch set", 1, write_enable_latch);
      cmd(ops[i], a, kinds[i] != OPK_CE);
      check("busy start", 1, busy_flag);
      wait_busy(1'b0, 2000);
      check("erase kind", kinds[i], go_kind);
      check("erase base", exp_base(kinds[i], a), go_base);
      check("erase fill", `ERASED_BYTE, erase_fill);
      check("latch cleared", 0, write_enable_latch);
    end
    check("erase count", 5, n_go);
    four_wire_command_framing = 1'b0;
    $display("test erase_kinds done");
    a = 24'($urandom);
    target_protected = 1'b1;
    wren();
    cmd(`OP_BE64, a, 1'b1);
    check("busy protected", 0, busy_flag);
    check("query address", a, protect_query_addr);
    target_protected = 1'b0;
    any_region_protected = 1'b1;
    cmd(`OP_CE1, 24'h0, 1'b0);
    check("busy chip protected", 0, busy_flag);
    any_region_protected = 1'b0;
    wren();
    flash_host_model_inst.frame(36, {28'h0, `OP_SE, a, 4'ha}, 0);
    check("busy broken frame", 0, busy_flag);
    $display("test refusals done");
    a = {a[23:8], 8'hfe};
    wren();
    prog(`OP_QPROG, a, 24'ha1b2c3, 3);
    check("busy quad off", 0, busy_flag);
    quad_io_enable_bit = 1'b1;
    prog(`OP_QPROG, a, 24'ha1b2c3, 3);
    wait_busy(1'b0, 1500);
    check("write count", 3, n_we);
    check("column fe", 8'ha1, col_data[8'hfe]);
    check("column ff", 8'hb2, col_data[8'hff]);
    check("column 00", 8'hc3, col_data[8'h00]);
    check("page address", {a[23:8], 8'hff}, we_addr);
    check("latch after program", 0, write_enable_latch);
    $display("test quad_program done");
    cmd(`OP_SUSP, 24'h0, 1'b0);
    check("suspend when idle", 0, suspended_flag);
    a = 24'($urandom);
    wren();
    cmd(`OP_SE, a, 1'b1);
    cmd(`OP_SUSP, 24'h0, 1'b0);
    check("suspended", 1, suspended_flag);
    wait_busy(1'b0, 210);
    check("busy after latency", 0, busy_flag);
    wren();
    cmd(`OP_BE32, a ^ 24'h400000, 1'b1);
    check("erase in erase suspend", 0, busy_flag);
    prog(`OP_PROG, a ^ 24'h400000, 24'h00003c, 1);
    wait_busy(1'b1, 20);
    check("program elsewhere", 1, busy_flag);
    wait_busy(1'b0, 800);
    check("nested data", 8'h3c, col_data[a[7:0]]);
    check("still suspended", 1, suspended_flag);
    cmd(`OP_RESUME, 24'h0, 1'b0);
    check("resume flag", 0, suspended_flag);
    check("resume busy", 1, busy_flag);
    wait_busy(1'b0, 1600);
    check("resumed base", a & `SECTOR_MASK, go_base);
    $display("test erase_suspend done");
    wren();
    cmd(`OP_CE2, 24'h0, 1'b0);
    cmd(`OP_SUSP, 24'h0, 1'b0);
    check("chip erase unsuspended", 0, suspended_flag);
    wait_busy(1'b0, 700);
    check("chip erase kind", OPK_CE, go_kind);
    $display("test chip_suspend done");
    wren();
    prog(`OP_PROG, a, 24'h000055, 1);
    cmd(`OP_SUSP, 24'h0, 1'b0);
    check("program suspended", 1, suspended_flag);
    wait_busy(1'b0, 210);
    wren();
    prog(`OP_PROG, a ^ 24'h400000, 24'h000066, 1);
    check("program in program suspend", 0, busy_flag);
    do_reset();
    check("flag after reset", 0, suspended_flag);
    check("latch after reset", 0, write_enable_latch);
    $display("test power_loss done");
    tally_and_finish();
  end
endmodule
